// file: verilog/tsirq_defines.svh
`ifndef TSIRQ_DEFINES_SVH
`define TSIRQ_DEFINES_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define TSIRQ_ADDR_W 16
`define TSIRQ_DATA_W 32
`define TSIRQ_NSRC 10

// ****************************************************************
// controller window and register offsets
// ****************************************************************
`define TSIRQ_WIN_SEL 4'h3
`define TSIRQ_OFS_DISABLE 12'h020
`define TSIRQ_OFS_ENABLE 12'h024
`define TSIRQ_OFS_MASK 12'h028
`define TSIRQ_OFS_STATUS 12'h02c

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define TSIRQ_QUEUE_LSB 0
`define TSIRQ_QUEUE_MSB 4
`define TSIRQ_ACQ_LSB 5
`define TSIRQ_ACQ_MSB 9
`define TSIRQ_MASK_RST 10'h000
`define TSIRQ_PEND_RST 10'h000
`define TSIRQ_UNUSED_ZERO 22'h000000

`endif

// file: verilog/tsirq_pkg.sv
`default_nettype none

package tsirq_pkg;

  // one bit per source, same layout in every register
  typedef logic [9:0] tsirq_src_t;

  // register selected by an access inside the controller window
  typedef enum logic [4:0] {
    TSIRQ_SEL_NONE    = 5'h01,
    TSIRQ_SEL_DISABLE = 5'h02,
    TSIRQ_SEL_ENABLE  = 5'h04,
    TSIRQ_SEL_MASK    = 5'h08,
    TSIRQ_SEL_STATUS  = 5'h10
  } tsirq_sel_t;

endpackage

`default_nettype wire

// file: verilog/tsirq_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsirq_defines.svh"

module tsirq_sync (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [`TSIRQ_NSRC-1:0] i_async,
  output logic [`TSIRQ_NSRC-1:0] o_sync
);

  logic [`TSIRQ_NSRC-1:0] meta_q;
  logic [`TSIRQ_NSRC-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= `TSIRQ_PEND_RST;
      sync_q <= `TSIRQ_PEND_RST;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// file: verilog/tsirq_ctrl.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tsirq_defines.svh"

// Summary of operation
// - controller answers only in window 0x3000-0x3fff
// - disable 0x20, enable 0x24, mask 0x28
// - queue sources bits 0-4, acquisition 5-9
// - disable write clears mask bits written one
// - enable write sets mask bits written one
// - mask register reads enable state, ignores writes
// - mask changes only through enable or disable
// - status at 0x2c shows pending, write-one clears
// - queue source pends while its queue holds data
// - acquisition source pends while channel ready
module tsirq_ctrl (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register port
  input wire logic [`TSIRQ_ADDR_W-1:0] i_addr,
  input wire logic [`TSIRQ_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`TSIRQ_DATA_W-1:0] o_rdata,
  // timestamp queue not-empty levels
  input wire logic i_ts_queue_ch1_irq,
  input wire logic i_ts_queue_ch2_irq,
  input wire logic i_ts_queue_ch3_irq,
  input wire logic i_ts_queue_ch4_irq,
  input wire logic i_ts_queue_ch5_irq,
  // acquisition ready levels
  input wire logic i_acq_ready_ch1_irq,
  input wire logic i_acq_ready_ch2_irq,
  input wire logic i_acq_ready_ch3_irq,
  input wire logic i_acq_ready_ch4_irq,
  input wire logic i_acq_ready_ch5_irq,
  // interrupt request
  output logic o_irq
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n_q;

  // assertion is immediate, release waits two edges
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // source gathering
  // ****************************************************************
  tsirq_pkg::tsirq_src_t src_raw;
  tsirq_pkg::tsirq_src_t src_s;

  // sources come from the timestamp logic, possibly another clock
  assign src_raw = {
    i_acq_ready_ch5_irq,
    i_acq_ready_ch4_irq,
    i_acq_ready_ch3_irq,
    i_acq_ready_ch2_irq,
    i_acq_ready_ch1_irq,
    i_ts_queue_ch5_irq,
    i_ts_queue_ch4_irq,
    i_ts_queue_ch3_irq,
    i_ts_queue_ch2_irq,
    i_ts_queue_ch1_irq
  };

  tsirq_sync u_src_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n_q),
    .i_async(src_raw),
    .o_sync(src_s)
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic tsirq_pkg::tsirq_sel_t decode(
    input logic [`TSIRQ_ADDR_W-1:0] addr
  );
    tsirq_pkg::tsirq_sel_t sel;
    sel = tsirq_pkg::TSIRQ_SEL_NONE;
    if (addr[15:12] == `TSIRQ_WIN_SEL) begin
      unique case (addr[11:0])
        `TSIRQ_OFS_DISABLE: sel = tsirq_pkg::TSIRQ_SEL_DISABLE;
        `TSIRQ_OFS_ENABLE: sel = tsirq_pkg::TSIRQ_SEL_ENABLE;
        `TSIRQ_OFS_MASK: sel = tsirq_pkg::TSIRQ_SEL_MASK;
        `TSIRQ_OFS_STATUS: sel = tsirq_pkg::TSIRQ_SEL_STATUS;
        default: sel = tsirq_pkg::TSIRQ_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // every readable word is the ten source bits, zero above
  function automatic logic [`TSIRQ_DATA_W-1:0] pack_word(
    input tsirq_pkg::tsirq_src_t bits
  );
    return {`TSIRQ_UNUSED_ZERO, bits};
  endfunction

  tsirq_pkg::tsirq_sel_t sel;
  tsirq_pkg::tsirq_src_t wbits;
  logic wr_dis;
  logic wr_en;
  logic wr_stat;
  logic wr_mask;
  logic rd_mask;
  logic rd_stat;
  logic rd_wo;
  logic rd_miss;

  assign sel = decode(i_addr);
  // upper data bits are simply not looked at
  assign wbits = i_wdata[`TSIRQ_NSRC-1:0];
  assign wr_dis = i_wr && (sel == tsirq_pkg::TSIRQ_SEL_DISABLE);
  assign wr_en = i_wr && (sel == tsirq_pkg::TSIRQ_SEL_ENABLE);
  assign wr_stat = i_wr && (sel == tsirq_pkg::TSIRQ_SEL_STATUS);
  assign wr_mask = i_wr && (sel == tsirq_pkg::TSIRQ_SEL_MASK);
  assign rd_mask = i_rd && (sel == tsirq_pkg::TSIRQ_SEL_MASK);
  assign rd_stat = i_rd && (sel == tsirq_pkg::TSIRQ_SEL_STATUS);
  assign rd_wo = i_rd && ((sel == tsirq_pkg::TSIRQ_SEL_DISABLE) ||
                          (sel == tsirq_pkg::TSIRQ_SEL_ENABLE));
  assign rd_miss = i_rd && (sel == tsirq_pkg::TSIRQ_SEL_NONE);

  // ****************************************************************
  // mask register
  // ****************************************************************
  tsirq_pkg::tsirq_src_t mask_q;
  tsirq_pkg::tsirq_src_t mask_d;

  // strobes never coincide, so enable and disable cannot collide
  always_comb begin
    mask_d = mask_q;
    if (wr_en) begin
      mask_d = mask_q | wbits;
    end else if (wr_dis) begin
      mask_d = mask_q & ~wbits;
    end
  end

  // a write to the mask address itself falls through untouched
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= `TSIRQ_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // pending register
  // ****************************************************************
  tsirq_pkg::tsirq_src_t pend_q;
  tsirq_pkg::tsirq_src_t pend_d;
  tsirq_pkg::tsirq_src_t pend_clr;

  assign pend_clr = wr_stat ? wbits : `TSIRQ_PEND_RST;

  // a live level re-pends in the same cycle: set beats clear
  always_comb begin
    pend_d = (pend_q & ~pend_clr) | src_s;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= `TSIRQ_PEND_RST;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  logic irq_q;

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(pend_q & mask_q);
    end
  end

  assign o_irq = irq_q;

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [`TSIRQ_DATA_W-1:0] rdata_q;

  // data stand for one cycle only, zero otherwise
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (rd_mask) begin
      rdata_q <= pack_word(mask_q);
    end else if (rd_stat) begin
      rdata_q <= pack_word(pend_q);
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_rdata = rdata_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n_q);

  chk_enable_sets: assert property (
    wr_en |=> ((mask_q & $past(wbits)) == $past(wbits)) &&
      ((mask_q & ~$past(wbits)) == ($past(mask_q) & ~$past(wbits)))
  ) else $error("enable write did not set mask bits");

  chk_disable_clears: assert property (
    wr_dis |=> ((mask_q & $past(wbits)) == '0) &&
      ((mask_q & ~$past(wbits)) == ($past(mask_q) & ~$past(wbits)))
  ) else $error("disable write did not clear mask bits");

  chk_mask_holds: assert property (
    !(wr_en || wr_dis) |=> mask_q == $past(mask_q)
  ) else $error("mask changed without enable or disable");

  chk_mask_readback: assert property (
    rd_mask ##1 1'b1 |-> o_rdata == {`TSIRQ_UNUSED_ZERO, $past(mask_q)}
  ) else $error("mask read returned wrong value");

  chk_mask_ro: assert property (
    wr_mask |=> $stable(mask_q)
  ) else $error("write to mask register changed it");

  chk_mask_rd_quiet: assert property (
    i_rd |=> $stable(mask_q)
  ) else $error("read changed the mask");

  // writes elsewhere in the map leave all state alone
  chk_miss_write: assert property (
    (i_wr && (sel == tsirq_pkg::TSIRQ_SEL_NONE)) |=>
      (mask_q == $past(mask_q)) &&
      ((pend_q & ~$past(src_s)) == ($past(pend_q) & ~$past(src_s)))
  ) else $error("write outside the window changed state");

  // ****************************************************************
  // pending and source synchroniser checks
  // ****************************************************************

  chk_status_clear: assert property (
    wr_stat |=> (pend_q & $past(wbits) & ~$past(src_s)) == '0
  ) else $error("status write one did not clear pending");

  chk_queue_pends: assert property (
    (src_s[`TSIRQ_QUEUE_MSB:`TSIRQ_QUEUE_LSB] != '0) |=>
      (pend_q[4:0] & $past(src_s[4:0])) == $past(src_s[4:0])
  ) else $error("queue level did not pend");

  chk_acq_pends: assert property (
    (src_s[`TSIRQ_ACQ_MSB:`TSIRQ_ACQ_LSB] != '0) |=>
      (pend_q[9:5] & $past(src_s[9:5])) == $past(src_s[9:5])
  ) else $error("acquisition level did not pend");

  chk_pend_sticky: assert property (
    !wr_stat |=> (pend_q & $past(pend_q)) == $past(pend_q)
  ) else $error("pending bit dropped without a clear");

  // a pending bit may only rise behind a live source level
  chk_pend_source_only: assert property (
    (pend_q & ~$past(pend_q) & ~$past(src_s)) == '0
  ) else $error("pending bit set with no source level");

  // only the second stage may be read, two edges behind the pin
  chk_sync_latency: assert property (
    ($past(rst_n_q, 2) && $past(rst_n_q)) |-> src_s == $past(src_raw, 2)
  ) else $error("source level not delayed by two stages");

  // mask writes never touch pending state
  chk_mask_write_pend: assert property (
    (wr_en || wr_dis) |=>
      (pend_q & ~$past(src_s)) == ($past(pend_q) & ~$past(src_s))
  ) else $error("mask write changed pending bits");

  chk_status_readback: assert property (
    rd_stat |=> o_rdata == {`TSIRQ_UNUSED_ZERO, $past(pend_q)}
  ) else $error("status read returned wrong value");

  // ****************************************************************
  // interrupt and read data checks
  // ****************************************************************

  chk_irq_follows: assert property (
    ((pend_q & mask_q) != '0) |=> o_irq
  ) else $error("irq low while enabled source pending");

  chk_irq_quiet: assert property (
    ((pend_q & mask_q) == '0) |=> !o_irq
  ) else $error("irq high with nothing enabled pending");

  chk_upper_zero: assert property (
    i_rd |=> o_rdata[31:10] == `TSIRQ_UNUSED_ZERO
  ) else $error("upper read bits not zero");

  chk_window_miss: assert property (
    (rd_miss || rd_wo) |=> o_rdata == '0
  ) else $error("unmapped or write-only read not zero");

  chk_enable_to_irq: assert property (
    (wr_en && ((wbits & pend_q & src_s) != '0)) |=> ##1 o_irq
  ) else $error("enable of pending source gave no irq");

  // a source live in the disable cycle still counts as pending
  chk_disable_quiets: assert property (
    (wr_dis && (((pend_q | src_s) & mask_q & ~wbits) == '0)) |=>
      ##1 !o_irq
  ) else $error("irq high after last pending source disabled");

  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == '0
  ) else $error("read data stood beyond its cycle");

  cov_enable_irq: cover property (wr_en ##1 1'b1 ##1 o_irq);
  cov_status_clear: cover property (o_irq ##1 wr_stat ##2 !o_irq);
  cov_disable_quiet: cover property (o_irq ##1 wr_dis ##2 !o_irq);
  cov_set_beats_clear: cover property (wr_stat && ((wbits & src_s) != '0));
  cov_miss_write: cover property (i_wr && (sel == tsirq_pkg::TSIRQ_SEL_NONE));

endmodule

`default_nettype wire

// file: verification/timestamp_irq_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsirq_defines.svh"

`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module timestamp_irq_controller_test;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic i_clk_sys;
  logic i_rst_n;
  logic [15:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [9:0] src;
  logic [31:0] o_rdata;
  logic o_irq;
  int errors;
  int check_count;

  tsirq_ctrl tsirq_ctrl_i (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_ts_queue_ch1_irq(src[0]),
    .i_ts_queue_ch2_irq(src[1]),
    .i_ts_queue_ch3_irq(src[2]),
    .i_ts_queue_ch4_irq(src[3]),
    .i_ts_queue_ch5_irq(src[4]),
    .i_acq_ready_ch1_irq(src[5]),
    .i_acq_ready_ch2_irq(src[6]),
    .i_acq_ready_ch3_irq(src[7]),
    .i_acq_ready_ch4_irq(src[8]),
    .i_acq_ready_ch5_irq(src[9]),
    .o_irq(o_irq)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic end_sim();
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, exp)
  endtask

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    // settle past the edge that may be launching o_irq
    #1;
    while (o_irq !== v && n < 8) begin
      cycles(1);
      n++;
    end
    `CHK(o_irq, v)
    if (o_irq !== v) begin
      end_sim();
    end
  endtask

  task automatic pulse_src(input logic [9:0] v);
    @(posedge i_clk_sys);
    src <= v;
    cycles(5);
    @(posedge i_clk_sys);
    src <= 10'h000;
    cycles(3);
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    i_rst_n = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    src = 10'h000;
    errors = 0;
    check_count = 0;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    cycles(3);
    `CHK(o_irq, 1'b0)
    rd_chk(16'h3028, 32'h0000_0000);
    rd_chk(16'h302c, 32'h0000_0000);
    wr_reg(16'h3024, 32'hffff_ffff);
    rd_chk(16'h3028, 32'h0000_03ff);
    cycles(1);
    `CHK(o_rdata, 32'h0000_0000)
    wr_reg(16'h3020, 32'h0000_00a5);
    rd_chk(16'h3028, 32'h0000_035a);
    wr_reg(16'h3024, 32'h0000_0000);
    wr_reg(16'h3028, 32'h0000_0000);
    wr_reg(16'h2024, 32'h0000_03ff);
    wr_reg(16'h4020, 32'h0000_03ff);
    wr_reg(16'h3030, 32'h0000_03ff);
    rd_chk(16'h3028, 32'h0000_035a);
    rd_chk(16'h3020, 32'h0000_0000);
    rd_chk(16'h3024, 32'h0000_0000);
    rd_chk(16'h2028, 32'h0000_0000);
    wr_reg(16'h3020, 32'h0000_03ff);
    rd_chk(16'h3028, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      pulse_src(10'h001 << i);
      `CHK(o_irq, 1'b0)
      rd_chk(16'h302c, 32'h0000_0001 << i);
      wr_reg(16'h302c, 32'h0000_0001 << i);
      rd_chk(16'h302c, 32'h0000_0000);
    end
    pulse_src(10'h080);
    wr_reg(16'h3024, 32'h0000_0080);
    wait_irq(1'b1);
    wr_reg(16'h3020, 32'h0000_0080);
    wait_irq(1'b0);
    wr_reg(16'h3024, 32'h0000_037f);
    cycles(4);
    `CHK(o_irq, 1'b0)
    wr_reg(16'h3024, 32'h0000_0080);
    wait_irq(1'b1);
    // zeros written to status must leave the pending bit alone
    wr_reg(16'h302c, 32'h0000_037f);
    cycles(3);
    `CHK(o_irq, 1'b1)
    wr_reg(16'h302c, 32'h0000_0080);
    wait_irq(1'b0);
    // a source still high re-sets its pending bit after a clear
    @(posedge i_clk_sys);
    src <= 10'h001;
    cycles(5);
    wr_reg(16'h302c, 32'h0000_0001);
    rd_chk(16'h302c, 32'h0000_0001);
    wait_irq(1'b1);
    pulse_src(10'h000);
    wr_reg(16'h302c, 32'h0000_0001);
    wait_irq(1'b0);
    rd_chk(16'h302c, 32'h0000_0000);
    // a reset in mid-run drops mask, pending and the request line
    @(posedge i_clk_sys);
    src <= 10'h001;
    wait_irq(1'b1);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    src <= 10'h000;
    cycles(2);
    `CHK(o_irq, 1'b0)
    `CHK(o_rdata, 32'h0000_0000)
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    cycles(3);
    rd_chk(16'h3028, 32'h0000_0000);
    rd_chk(16'h302c, 32'h0000_0000);
    end_sim();
  end
endmodule

`undef CHK
`default_nettype wire
